// >>> pdo_assign_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pdo_assign_checker (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic                    pslverr,
  input wire pdo_assign_pkg::assign_t active_tx
);
  import pdo_assign_pkg::*;
  // ----------------------------------------------------------------
  // decode and shadows of state and transmit count
  // ----------------------------------------------------------------
  wire wr     = psel & penable & pwrite;
  wire ok_wr  = wr & ~pslverr;
  wire ent_tx = wr && paddr >= OFF_TX_ENTRY1 && paddr <= OFF_TX_ENTRY4;
  wire ent_rx = wr && paddr >= OFF_RX_ENTRY1 && paddr <= OFF_RX_ENTRY4;
  wire cnt_wr = wr && (paddr == OFF_RX_COUNT || paddr == OFF_TX_COUNT);
  wire sv_wr  = wr && paddr == OFF_ESM_STATE && pwdata[3:0] == 4'h4;
  logic [3:0] st;
  logic [7:0] tx_cnt;
  // state shadow only follows accepted, known codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= 4'h1;
    end else if (ok_wr && paddr == OFF_ESM_STATE &&
                 pwdata[3:0] inside {4'h1, 4'h2, 4'h4, 4'h8}) begin
      st <= pwdata[3:0];
    end
  end
  // count shadow, so lock checks need no read-back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt <= RESET_COUNT;
    end else if (ok_wr && paddr == OFF_TX_COUNT) begin
      tx_cnt <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence to_safeop_s;
    sv_wr && st != 4'h4;
  endsequence
  count_range_a: assert property (
    cnt_wr && pwdata[7:0] > COUNT_MAX |-> pslverr)
    else $error("count above four accepted");
  tx_range_a: assert property (
    ent_tx && !(pwdata[15:0] inside {[TX_MAP_FIRST:TX_MAP_LAST]}) |-> pslverr)
    else $error("transmit entry out of range accepted");
  rx_range_a: assert property (
    ent_rx && !(pwdata[15:0] inside {[RX_MAP_FIRST:RX_MAP_LAST]}) |-> pslverr)
    else $error("receive entry out of range accepted");
  lock_refuse_a: assert property (
    ent_tx && (st != 4'h2 || tx_cnt != 8'h00) |-> pslverr)
    else $error("locked entry write accepted");
  good_write_a: assert property (
    ent_tx && st == 4'h2 && tx_cnt == 8'h00 && pstrb == 4'hf &&
    pwdata[15:0] inside {[TX_MAP_FIRST:TX_MAP_LAST]} |-> !pslverr)
    else $error("legal entry write refused");
  tx_activate_a: assert property (
    to_safeop_s |-> ##2 active_tx.count == $past(tx_cnt, 2))
    else $error("count not in force after safeop");
  active_hold_a: assert property (
    !sv_wr ##1 !sv_wr |=> $stable(active_tx))
    else $error("tables changed without safeop");
  err_access_a: assert property (
    pslverr |-> psel && penable)
    else $error("error outside access cycle");
endmodule : pdo_assign_checker
bind pdo_assign_objects pdo_assign_checker chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .active_tx(active_tx));
`default_nettype wire

// >>> pdo_assign_objects.sv
`timescale 1ns/1ns
`default_nettype none

module pdo_assign_objects (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output pdo_assign_pkg::assign_t          active_rx,
  output pdo_assign_pkg::assign_t          active_tx
);
  import pdo_assign_pkg::*;

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // entry slot of an address relative to an object base, or NUM_ENTRIES
  function automatic logic [2:0] entry_slot(input logic [11:0] a,
                                            input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    entry_slot = 3'(NUM_ENTRIES);
    for (int k = 0; k < NUM_ENTRIES; k++) begin
      if (d == 12'((k + 1) * ENTRY_STRIDE)) begin
        entry_slot = 3'(k);
      end
    end
  endfunction : entry_slot

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  assign_t    rx_obj;
  assign_t    tx_obj;
  esm_t       esm_state;
  esm_t       esm_prev;
  wr_status_t last_wr;

  logic        wr_acc;
  logic        rd_acc;
  logic [2:0]  rx_slot;
  logic [2:0]  tx_slot;
  logic        hit_rx_cnt;
  logic        hit_tx_cnt;
  logic        hit_rx_ent;
  logic        hit_tx_ent;
  logic        hit_esm;
  logic        in_preop;
  logic        full_word;
  logic [31:0] next_abort;
  logic        mapped;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign rx_slot = entry_slot(paddr, OFF_RX_COUNT);
  assign tx_slot = entry_slot(paddr, OFF_TX_COUNT);
  assign hit_rx_cnt = (paddr == OFF_RX_COUNT);
  assign hit_tx_cnt = (paddr == OFF_TX_COUNT);
  assign hit_rx_ent = (rx_slot != 3'(NUM_ENTRIES));
  assign hit_tx_ent = (tx_slot != 3'(NUM_ENTRIES));
  assign hit_esm    = (paddr == OFF_ESM_STATE);
  assign in_preop   = (esm_state == ESM_PREOP);
  // objects are written whole; partial strobes are treated as illegal except on the state register
  assign full_word  = (pstrb == 4'hf);

  // ----------------------------------------------------------------------
  // write legality, evaluated in the access cycle
  // ----------------------------------------------------------------------
  always_comb begin
    next_abort = ABORT_NONE;
    if (hit_rx_ent || hit_tx_ent) begin
      if (!in_preop) begin
        next_abort = ABORT_NO_WRITE;
      end else if (hit_rx_ent && rx_obj.count != 8'h00) begin
        next_abort = ABORT_NO_WRITE;
      end else if (hit_tx_ent && tx_obj.count != 8'h00) begin
        next_abort = ABORT_NO_WRITE;
      end else if (hit_rx_ent &&
                   !in_range(16'(pwdata), RX_MAP_FIRST, RX_MAP_LAST)) begin
        next_abort = ABORT_RANGE;
      end else if (hit_tx_ent &&
                   !in_range(16'(pwdata), TX_MAP_FIRST, TX_MAP_LAST)) begin
        next_abort = ABORT_RANGE;
      end
    end else if (hit_rx_cnt || hit_tx_cnt) begin
      if (!in_preop) begin
        next_abort = ABORT_NO_WRITE;
      end else if (pwdata[7:0] > COUNT_MAX) begin
        next_abort = ABORT_RANGE;
      end
    end
    if (!full_word && next_abort == ABORT_NONE && !hit_esm) begin
      next_abort = ABORT_RANGE;
    end
  end

  assign mapped = hit_rx_cnt || hit_tx_cnt || hit_rx_ent || hit_tx_ent ||
                  hit_esm || (paddr == OFF_STATUS) ||
                  (paddr == OFF_ACT_RX_CNT) || (paddr == OFF_ACT_TX_CNT) ||
                  (paddr[11:4] == OFF_ACT_RX_E0[11:4]) ||
                  (paddr[11:4] == OFF_ACT_TX_E0[11:4]);

  // error answer on refused writes and unmapped addresses
  assign pslverr = psel && penable &&
                   (!mapped || (pwrite && next_abort != ABORT_NONE));

  // ----------------------------------------------------------------------
  // receive-side assignment object
  // ----------------------------------------------------------------------
  // a refused write simply does not load, so the old value stays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_obj.count <= RESET_COUNT;
      for (int k = 0; k < NUM_ENTRIES; k++) begin
        rx_obj.entry[k] <= RESET_RX_ENTRY;
      end
    end else if (wr_acc && next_abort == ABORT_NONE) begin
      if (hit_rx_cnt) begin
        rx_obj.count <= pwdata[7:0];
      end else if (hit_rx_ent) begin
        rx_obj.entry[rx_slot[1:0]] <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmit-side assignment object (sync manager 3, input data)
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_obj.count <= RESET_COUNT;
      for (int k = 0; k < NUM_ENTRIES; k++) begin
        tx_obj.entry[k] <= RESET_TX_ENTRY;
      end
    end else if (wr_acc && next_abort == ABORT_NONE) begin
      if (hit_tx_cnt) begin
        tx_obj.count <= pwdata[7:0];
      end else if (hit_tx_ent) begin
        tx_obj.entry[tx_slot[1:0]] <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // slave state as reported by the state-machine firmware
  // ----------------------------------------------------------------------
  // only one-hot codes are accepted; anything else is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esm_state <= ESM_INIT;
    end else if (wr_acc && hit_esm) begin
      case (pwdata[3:0])
        ESM_INIT:   esm_state <= ESM_INIT;
        ESM_PREOP:  esm_state <= ESM_PREOP;
        ESM_SAFEOP: esm_state <= ESM_SAFEOP;
        ESM_OP:     esm_state <= ESM_OP;
        default:    esm_state <= esm_state;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esm_prev <= ESM_INIT;
    end else begin
      esm_prev <= esm_state;
    end
  end

  // ----------------------------------------------------------------------
  // activation: copy the tables on the step into SafeOP
  // ----------------------------------------------------------------------
  // the running tables never see half-edited settings from PreOP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_rx.count <= RESET_COUNT;
      active_tx.count <= RESET_COUNT;
      for (int k = 0; k < NUM_ENTRIES; k++) begin
        active_rx.entry[k] <= RESET_RX_ENTRY;
        active_tx.entry[k] <= RESET_TX_ENTRY;
      end
    end else if (esm_state == ESM_SAFEOP && esm_prev != ESM_SAFEOP) begin
      active_rx <= rx_obj;
      active_tx <= tx_obj;
    end
  end

  // ----------------------------------------------------------------------
  // last write outcome
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_wr <= '0;
    end else if (wr_acc && mapped) begin
      last_wr.refused    <= (next_abort != ABORT_NONE);
      last_wr.abort_code <= next_abort;
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      if (hit_rx_cnt) begin
        prdata = {24'h00_0000, rx_obj.count};
      end else if (hit_tx_cnt) begin
        prdata = {24'h00_0000, tx_obj.count};
      end else if (hit_rx_ent) begin
        prdata = {16'h0000, rx_obj.entry[rx_slot[1:0]]};
      end else if (hit_tx_ent) begin
        prdata = {16'h0000, tx_obj.entry[tx_slot[1:0]]};
      end else if (hit_esm) begin
        prdata = {28'h000_0000, esm_state};
      end else if (paddr == OFF_STATUS) begin
        prdata = last_wr.abort_code;
      end else if (paddr == OFF_ACT_RX_CNT) begin
        prdata = {24'h00_0000, active_rx.count};
      end else if (paddr == OFF_ACT_TX_CNT) begin
        prdata = {24'h00_0000, active_tx.count};
      end else if (paddr[11:4] == OFF_ACT_RX_E0[11:4]) begin
        prdata = {16'h0000, active_rx.entry[paddr[3:2]]};
      end else if (paddr[11:4] == OFF_ACT_TX_E0[11:4]) begin
        prdata = {16'h0000, active_tx.entry[paddr[3:2]]};
      end
    end
  end

endmodule : pdo_assign_objects
`default_nettype wire

// >>> pdo_assign_pkg.sv
package pdo_assign_pkg;

  // ----------------------------------------------------------------------
  // register map (byte offsets, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_RX_COUNT   = 12'h000;
  localparam logic [11:0] OFF_RX_ENTRY1  = 12'h004;
  localparam logic [11:0] OFF_RX_ENTRY2  = 12'h008;
  localparam logic [11:0] OFF_RX_ENTRY3  = 12'h00c;
  localparam logic [11:0] OFF_RX_ENTRY4  = 12'h010;
  localparam logic [11:0] OFF_TX_COUNT   = 12'h020;
  localparam logic [11:0] OFF_TX_ENTRY1  = 12'h024;
  localparam logic [11:0] OFF_TX_ENTRY2  = 12'h028;
  localparam logic [11:0] OFF_TX_ENTRY3  = 12'h02c;
  localparam logic [11:0] OFF_TX_ENTRY4  = 12'h030;
  localparam logic [11:0] OFF_ESM_STATE  = 12'h040;
  localparam logic [11:0] OFF_STATUS     = 12'h044;
  localparam logic [11:0] OFF_ACT_RX_CNT = 12'h048;
  localparam logic [11:0] OFF_ACT_TX_CNT = 12'h04c;
  localparam logic [11:0] OFF_ACT_RX_E0  = 12'h050;
  localparam logic [11:0] OFF_ACT_TX_E0  = 12'h060;
  localparam logic [11:0] ENTRY_STRIDE   = 12'h004;

  // ----------------------------------------------------------------------
  // value ranges and codes
  // ----------------------------------------------------------------------
  localparam int          NUM_ENTRIES   = 4;
  localparam logic [7:0]  COUNT_MAX     = 8'h04;
  localparam logic [15:0] RX_MAP_FIRST  = 16'h1600;
  localparam logic [15:0] RX_MAP_LAST   = 16'h1603;
  localparam logic [15:0] TX_MAP_FIRST  = 16'h1a00;
  localparam logic [15:0] TX_MAP_LAST   = 16'h1a03;
  localparam logic [31:0] ABORT_NO_WRITE = 32'h0601_0003;
  localparam logic [31:0] ABORT_RANGE    = 32'h0609_0030;
  localparam logic [31:0] ABORT_NONE     = 32'h0000_0000;
  localparam logic [15:0] RESET_RX_ENTRY = 16'h1600;
  localparam logic [15:0] RESET_TX_ENTRY = 16'h1a00;
  localparam logic [7:0]  RESET_COUNT    = 8'h01;

  // slave state machine codes as software writes them
  typedef enum logic [3:0] {
    ESM_INIT   = 4'h1,
    ESM_PREOP  = 4'h2,
    ESM_SAFEOP = 4'h4,
    ESM_OP     = 4'h8
  } esm_t;

  // one assignment object: count plus four entries
  typedef struct packed {
    logic [7:0]                    count;
    logic [NUM_ENTRIES-1:0][15:0]  entry;
  } assign_t;

  // outcome of the last write
  typedef struct packed {
    logic        refused;
    logic [31:0] abort_code;
  } wr_status_t;

endpackage : pdo_assign_pkg

// >>> pdo_cfg_master.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// configuring master on the register bus
// ----------------------------------------------------------------
module pdo_cfg_master (
  input wire logic        pclk,
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic     [11:0] paddr,
  output logic     [31:0] pwdata,
  output logic     [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
  end
  // one transfer; released data is inverted so stale values never match
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : pdo_cfg_master
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pdo_assign_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  assign_t     active_rx, active_tx;
  int          err_total, n_tests;
  pdo_assign_objects pdo_assign_objects_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .active_rx(active_rx),
    .active_tx(active_tx));
  pdo_cfg_master pdo_cfg_master_inst (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------------------------------
  // clock, reset and checking helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // start high for a moment so the asynchronous reset sees a real edge
  initial begin
    presetn = 1'b1;
    #1 presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  end
  task cmp_data(input logic [11:0] a, input logic [31:0] x, g);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("Error data at %h expected %h seen %h", a, x, g);
    end
  endtask : cmp_data
  task cmp_err(input logic [11:0] a, input logic x, g);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("Error refusal at %h expected %b seen %b", a, x, g);
    end
  endtask : cmp_err
  task wrt(input logic [11:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic        g;
    pdo_cfg_master_inst.xfer(1'b1, a, d, r, g);
    cmp_err(a, e, g);
  endtask : wrt
  task rd(input logic [11:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic        g;
    pdo_cfg_master_inst.xfer(1'b0, a, 32'h0, r, g);
    cmp_err(a, e, g);
    cmp_data(a, d, r);
  endtask : rd
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  // the sequence needs some 130 cycles; 3000 means a hang
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    stop_test;
  end
  // tests: reset, locked, preop edits, activation
  initial begin
    err_total = 0;
    n_tests = 0;
    @(posedge presetn);
    rd(OFF_TX_COUNT, 32'(RESET_COUNT), 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(OFF_TX_ENTRY1 + 12'(4 * i), 32'(RESET_TX_ENTRY), 1'b0);
    end
    rd(OFF_RX_ENTRY4, 32'(RESET_RX_ENTRY), 1'b0);
    $display("test reset values done");
    wrt(OFF_TX_ENTRY1, 32'h1a01, 1'b1);
    wrt(OFF_TX_COUNT, 32'h0, 1'b1);
    rd(OFF_STATUS, ABORT_NO_WRITE, 1'b0);
    rd(OFF_TX_ENTRY1, 32'h1a00, 1'b0);
    $display("test locked state done");
    wrt(OFF_ESM_STATE, 32'(ESM_PREOP), 1'b0);
    wrt(OFF_TX_ENTRY2, 32'h1a02, 1'b1);
    rd(OFF_STATUS, ABORT_NO_WRITE, 1'b0);
    rd(OFF_TX_ENTRY2, 32'h1a00, 1'b0);
    wrt(OFF_TX_COUNT, 32'h5, 1'b1);
    wrt(OFF_TX_COUNT, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wrt(OFF_TX_ENTRY1 + 12'(4 * i), 32'h1a03 - i, 1'b0);
    end
    wrt(OFF_TX_ENTRY1, 32'h1a04, 1'b1);
    wrt(OFF_TX_ENTRY2, 32'h19ff, 1'b1);
    rd(OFF_TX_ENTRY1, 32'h1a03, 1'b0);
    wrt(OFF_RX_COUNT, 32'h0, 1'b0);
    wrt(OFF_RX_ENTRY3, 32'h1603, 1'b0);
    wrt(OFF_RX_ENTRY4, 32'h1a00, 1'b1);
    wrt(OFF_RX_COUNT, 32'h3, 1'b0);
    wrt(OFF_TX_COUNT, 32'h4, 1'b0);
    wrt(OFF_TX_ENTRY1, 32'h1a00, 1'b1);
    rd(OFF_ACT_TX_CNT, 32'h1, 1'b0);
    $display("test preop edits done");
    wrt(OFF_ESM_STATE, 32'(ESM_SAFEOP), 1'b0);
    rd(OFF_ACT_TX_CNT, 32'h4, 1'b0);
    rd(OFF_ACT_RX_CNT, 32'h3, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(OFF_ACT_TX_E0 + 12'(4 * i), 32'h1a03 - i, 1'b0);
    end
    rd(OFF_ACT_RX_E0 + 12'h008, 32'h1603, 1'b0);
    cmp_data(12'h000, 32'h3, 32'(active_rx.count));
    cmp_data(12'h000, 32'h1603, 32'(active_rx.entry[2]));
    cmp_data(12'h000, 32'h1a00, 32'(active_tx.entry[3]));
    wrt(OFF_TX_COUNT, 32'h0, 1'b1);
    wrt(12'h014, 32'h1, 1'b1);
    $display("test activation done");
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
